// File: logic/sicr_pkg.sv
// Package of constants and types for the switch input configuration registers
package sicr_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [5:0]  ADDR_CONFIG     = 6'h1a;
	localparam logic [5:0]  ADDR_INPUT_EN   = 6'h1b;
	localparam logic [5:0]  ADDR_DIR_SELECT = 6'h1c;
	localparam int          REG_W           = 24;
	localparam int          NUM_CH          = 24;
	localparam int          NUM_DIR         = 10;
	localparam int          CFG_RESET_BIT   = 0;
	localparam int          CFG_POLL_LSB    = 1;
	localparam int          CFG_POLL_MSB    = 4;
	localparam logic [3:0]  POLL_RESET      = 4'h0;
	localparam logic [23:0] INPUT_EN_RESET  = 24'h000000;
	localparam logic [9:0]  DIR_RESET       = 10'h000;
	// ****************************************
	// Serial frame layout
	// ****************************************
	localparam int          FRAME_BITS      = 32;
	localparam int          HDR_BITS        = 7;
	localparam int          FR_WRITE        = 31;
	localparam int          FR_ADDR_MSB     = 30;
	localparam int          FR_ADDR_LSB     = 25;
	localparam int          FR_DATA_MSB     = 24;
	localparam int          FR_DATA_LSB     = 1;
	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          MS_IN_NS        = 1000000;
	localparam int          CYCLES_PER_MS   = MS_IN_NS / CLK_PERIOD_NS;
	localparam logic [12:0] POLL_DEFAULT_MS = 13'd8;
	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} sicr_spi_in_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] channel;
	} sicr_poll_t;

	// Poll period in ms for a four-bit code
	function automatic logic [12:0] sicr_poll_ms(input logic [3:0] code);
		unique case (code)
			4'h0: sicr_poll_ms = 13'd2;
			4'h1: sicr_poll_ms = 13'd4;
			4'h2: sicr_poll_ms = 13'd8;
			4'h3: sicr_poll_ms = 13'd16;
			4'h4: sicr_poll_ms = 13'd32;
			4'h5: sicr_poll_ms = 13'd48;
			4'h6: sicr_poll_ms = 13'd64;
			4'h7: sicr_poll_ms = 13'd128;
			4'h8: sicr_poll_ms = 13'd256;
			4'h9: sicr_poll_ms = 13'd512;
			4'ha: sicr_poll_ms = 13'd1024;
			4'hb: sicr_poll_ms = 13'd2048;
			4'hc: sicr_poll_ms = 13'd4096;
			default: sicr_poll_ms = POLL_DEFAULT_MS;
		endcase
	endfunction : sicr_poll_ms
endpackage : sicr_pkg

// File: logic/sicr_poll_timer.sv
// Poll period timer: one start pulse per poll period
module sicr_poll_timer #(
	parameter int CYCLES_PER_MS = sicr_pkg::CYCLES_PER_MS
) (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_restart,
	input  wire logic [12:0] i_period_ms,
	output logic             o_start
);
	logic [31:0] cyc;
	logic [31:0] next_cyc;
	logic [12:0] ms;
	logic [12:0] next_ms;
	logic        next_start;

	always_comb
	begin
		next_cyc   = cyc + 32'h1;
		next_ms    = ms;
		next_start = 1'b0;
		if (i_restart)
		begin
			next_cyc = 32'h0;
			next_ms  = 13'h0;
		end
		else if (cyc >= 32'(CYCLES_PER_MS - 1))
		begin
			next_cyc = 32'h0;
			// Shortened period takes effect at once, no long wait
			if (ms + 13'h1 >= i_period_ms)
			begin
				next_ms    = 13'h0;
				next_start = 1'b1;
			end
			else
				next_ms = ms + 13'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cyc     <= 32'h0;
			ms      <= 13'h0;
			o_start <= 1'b0;
		end
		else
		begin
			cyc     <= next_cyc;
			ms      <= next_ms;
			o_start <= next_start;
		end
	end
endmodule : sicr_poll_timer

// File: logic/sicr_regs.sv
// Configuration registers behind the serial port, with poll timer and channel scan
module sicr_regs #(
	parameter int CYCLES_PER_MS = sicr_pkg::CYCLES_PER_MS
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_resetn,
	input  wire sicr_pkg::sicr_spi_in_t i_spi,
	output logic                       o_miso,
	output logic                       o_miso_oe_n,
	output logic [23:0]                o_input_enable,
	output logic [9:0]                 o_direction_select,
	output logic [12:0]                o_poll_period_ms,
	output logic                       o_soft_reset,
	output sicr_pkg::sicr_poll_t       o_poll
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	sicr_pkg::sicr_spi_in_t s1;
	sicr_pkg::sicr_spi_in_t s2;
	logic                   sclk_d;
	logic                   cs_d;

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			s1     <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
			s2     <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end
		else
		begin
			s1     <= i_spi;
			s2     <= s1;
			sclk_d <= s2.sclk;
			cs_d   <= s2.cs_n;
		end
	end

	logic rise;
	logic fall;
	logic frame_end;
	assign rise      = !s2.cs_n && s2.sclk && !sclk_d;
	assign fall      = !s2.cs_n && !s2.sclk && sclk_d;
	assign frame_end = s2.cs_n && !cs_d;

	// ****************************************
	// Register state
	// ****************************************
	logic [3:0]  poll_code;
	logic [23:0] in_en;
	logic [9:0]  dir_sel;
	logic        rst_pend;
	logic [31:0] sh_in;
	logic [23:0] sh_out;
	logic [5:0]  bits;
	logic [3:0]  next_poll_code;
	logic [23:0] next_in_en;
	logic [9:0]  next_dir_sel;
	logic        next_rst_pend;
	logic [31:0] next_sh_in;
	logic [23:0] next_sh_out;
	logic [5:0]  next_bits;
	logic        next_miso;
	logic        next_soft_reset;
	logic [23:0] rdata;
	logic        wr_valid;
	logic [5:0]  wr_addr;
	logic [23:0] wr_data;

	assign wr_valid = frame_end && bits == 6'(sicr_pkg::FRAME_BITS) && sh_in[sicr_pkg::FR_WRITE];
	assign wr_addr  = sh_in[sicr_pkg::FR_ADDR_MSB:sicr_pkg::FR_ADDR_LSB];
	assign wr_data  = sh_in[sicr_pkg::FR_DATA_MSB:sicr_pkg::FR_DATA_LSB];

	always_comb
	begin
		// Unmapped addresses read zero
		rdata = 24'h0;
		// Address comes from the shift register and pin, so no loop through next_sh_in
		unique case ({sh_in[4:0], s2.mosi})
			sicr_pkg::ADDR_CONFIG:     rdata = {19'h0, poll_code, rst_pend};
			sicr_pkg::ADDR_INPUT_EN:   rdata = in_en;
			sicr_pkg::ADDR_DIR_SELECT: rdata = {14'h0, dir_sel};
			default:                   rdata = 24'h0;
		endcase
	end

	always_comb
	begin
		next_poll_code  = poll_code;
		next_in_en      = in_en;
		next_dir_sel    = dir_sel;
		next_rst_pend   = 1'b0;
		next_soft_reset = 1'b0;
		next_sh_in      = sh_in;
		next_sh_out     = sh_out;
		next_bits       = bits;
		next_miso       = o_miso;
		if (rise && bits < 6'(sicr_pkg::FRAME_BITS))
		begin
			next_sh_in = {sh_in[30:0], s2.mosi};
			next_bits  = bits + 6'h1;
			// Read data ready as soon as the header is in
			if (bits == 6'(sicr_pkg::HDR_BITS - 1))
				next_sh_out = rdata;
		end
		if (fall && bits >= 6'(sicr_pkg::HDR_BITS) && bits < 6'(sicr_pkg::FRAME_BITS - 1))
		begin
			next_miso   = sh_out[23];
			next_sh_out = {sh_out[22:0], 1'b0};
		end
		if (s2.cs_n)
		begin
			next_bits = 6'h0;
			next_miso = 1'b0;
		end
		if (rst_pend)
		begin
			// Whole set back to defaults, bit self-clears
			next_poll_code  = sicr_pkg::POLL_RESET;
			next_in_en      = sicr_pkg::INPUT_EN_RESET;
			next_dir_sel    = sicr_pkg::DIR_RESET;
			next_soft_reset = 1'b1;
		end
		else if (wr_valid)
		begin
			unique case (wr_addr)
				sicr_pkg::ADDR_CONFIG:
				begin
					next_rst_pend  = wr_data[sicr_pkg::CFG_RESET_BIT];
					next_poll_code = wr_data[sicr_pkg::CFG_POLL_MSB:sicr_pkg::CFG_POLL_LSB];
				end
				sicr_pkg::ADDR_INPUT_EN:   next_in_en   = wr_data;
				sicr_pkg::ADDR_DIR_SELECT: next_dir_sel = wr_data[9:0];
				default:                   next_in_en   = in_en;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			poll_code    <= sicr_pkg::POLL_RESET;
			in_en        <= sicr_pkg::INPUT_EN_RESET;
			dir_sel      <= sicr_pkg::DIR_RESET;
			rst_pend     <= 1'b0;
			o_soft_reset <= 1'b0;
			sh_in        <= 32'h0;
			sh_out       <= 24'h0;
			bits         <= 6'h0;
			o_miso       <= 1'b0;
			o_miso_oe_n  <= 1'b1;
		end
		else
		begin
			poll_code    <= next_poll_code;
			in_en        <= next_in_en;
			dir_sel      <= next_dir_sel;
			rst_pend     <= next_rst_pend;
			o_soft_reset <= next_soft_reset;
			sh_in        <= next_sh_in;
			sh_out       <= next_sh_out;
			bits         <= next_bits;
			o_miso       <= next_miso;
			o_miso_oe_n  <= s2.cs_n;
		end
	end

	assign o_input_enable     = in_en;
	assign o_direction_select = dir_sel;

	// ****************************************
	// Poll timer and channel scan
	// ****************************************
	typedef enum logic {SCAN_IDLE, SCAN_RUN} sicr_scan_t;
	sicr_scan_t scan;
	sicr_scan_t next_scan;
	logic [4:0] ch;
	logic [4:0] next_ch;
	logic       start;
	logic [12:0] next_period;
	sicr_pkg::sicr_poll_t next_poll;

	sicr_poll_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_restart   (rst_pend),
		.i_period_ms (o_poll_period_ms),
		.o_start     (start)
	);

	always_comb
	begin
		next_period = sicr_pkg::sicr_poll_ms(poll_code);
		next_scan   = scan;
		next_ch     = ch;
		next_poll   = '{valid: 1'b0, channel: ch};
		unique case (scan)
			SCAN_IDLE:
				if (start)
				begin
					next_scan = SCAN_RUN;
					next_ch   = 5'h0;
				end
			SCAN_RUN:
			begin
				// Disabled channels keep their slot but are not marked valid
				next_poll.valid = in_en[ch];
				next_ch         = ch + 5'h1;
				if (ch == 5'(sicr_pkg::NUM_CH - 1))
					next_scan = SCAN_IDLE;
			end
		endcase
		if (rst_pend)
			next_scan = SCAN_IDLE;
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			scan             <= SCAN_IDLE;
			ch               <= 5'h0;
			o_poll           <= '{valid: 1'b0, channel: 5'h0};
			o_poll_period_ms <= 13'd2;
		end
		else
		begin
			scan             <= next_scan;
			ch               <= next_ch;
			o_poll           <= next_poll;
			o_poll_period_ms <= next_period;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	logic [23:0] en_q;
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			en_q <= 24'h0;
		else
			en_q <= in_en;
	end

	period_decode_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(poll_code > 4'hc) ##1 (poll_code > 4'hc) |=> o_poll_period_ms == 13'd8)
		else $error("Out of range poll code not giving 8 ms");
	soft_reset_go_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_valid && !rst_pend && wr_addr == sicr_pkg::ADDR_CONFIG && wr_data[0] |=> ##1 o_soft_reset)
		else $error("Software reset write not followed by reset pulse");
	skip_disabled_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_poll.valid |-> en_q[o_poll.channel])
		else $error("Disabled channel polled");
	enable_default_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_soft_reset |-> in_en == 24'h0)
		else $error("Input enables not cleared by reset");
	direction_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_valid && !rst_pend && wr_addr == sicr_pkg::ADDR_DIR_SELECT |=> dir_sel == $past(wr_data[9:0]))
		else $error("Direction select write lost");
	direction_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_soft_reset |-> dir_sel == 10'h0 && o_direction_select == 10'h0)
		else $error("Direction select not cleared by reset");
	reset_clears_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		rst_pend |=> !rst_pend && poll_code == 4'h0)
		else $error("Software reset bit did not return to zero");
endmodule : sicr_regs

// File: verification/sicr_host.sv
// Host model that drives the serial port of the register block
module sicr_host (
	input  wire logic             i_clk,
	input  wire logic             i_miso,
	output sicr_pkg::sicr_spi_in_t o_spi
);
	timeunit 1ns;
	timeprecision 100ps;

	initial o_spi = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};

	// ****************************************
	// Bus cycle
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick

	// Mode 0 frame; half sets speed, idle mosi shows the inverse of its last bit
	task automatic xfer(input logic [31:0] tx, input int half, output logic [23:0] rx);
		rx = '0;
		tick(1);
		o_spi.cs_n = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			o_spi.mosi = tx[i];
			tick(half);
			o_spi.sclk = 1'b1;
			if (i >= 1 && i <= 24)
				rx[i - 1] = i_miso;
			tick(half);
			o_spi.sclk = 1'b0;
		end
		tick(half);
		o_spi.cs_n = 1'b1;
		o_spi.mosi = ~o_spi.mosi;
		// Gap covers pin sync plus the write commit
		tick(8);
	endtask : xfer
endmodule : sicr_host

// File: verification/tb_switch_input_config_regs.sv
// Self-checking bench for the switch input configuration registers
module tb_switch_input_config_regs;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CPM = 20;
	logic                   i_clk;
	logic                   i_resetn;
	sicr_pkg::sicr_spi_in_t spi;
	logic                   miso;
	logic                   miso_oe_n;
	logic [23:0]            input_enable;
	logic [9:0]             direction_select;
	logic [12:0]            poll_period_ms;
	logic                   soft_reset;
	sicr_pkg::sicr_poll_t   poll;
	logic [23:0]            seen = '0;
	logic                   oe_low = 1'b0;
	int                     resets = 0;
	int                     mismatches = 0;
	int                     comparisons = 0;
	logic [31:0]            seed = 32'h710e;
	logic [23:0]            rd;
	logic [23:0]            val;
	logic [23:0]            en;

	sicr_regs #(.CYCLES_PER_MS(CPM)) dut (
		.i_clk              (i_clk),
		.i_resetn           (i_resetn),
		.i_spi              (spi),
		.o_miso             (miso),
		.o_miso_oe_n        (miso_oe_n),
		.o_input_enable     (input_enable),
		.o_direction_select (direction_select),
		.o_poll_period_ms   (poll_period_ms),
		.o_soft_reset       (soft_reset),
		.o_poll             (poll)
	);

	sicr_host host (.i_clk(i_clk), .i_miso(miso), .o_spi(spi));

	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Channels polled and soft resets seen
	always @(posedge i_clk)
	begin
		if (poll.valid === 1'b1)
			seen[poll.channel] <= 1'b1;
		if (soft_reset === 1'b1)
			resets <= resets + 1;
		if (miso_oe_n === 1'b0)
			oe_low <= 1'b1;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [12:0] exp_ms(input logic [3:0] c);
		logic [12:0] t [0:12];
		t = '{13'd2, 13'd4, 13'd8, 13'd16, 13'd32, 13'd48, 13'd64, 13'd128,
			13'd256, 13'd512, 13'd1024, 13'd2048, 13'd4096};
		return (c > 4'hc) ? 13'd8 : t[c];
	endfunction : exp_ms

	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Speed varies so the port meets slow and prompt hosts
	task automatic access(input logic wr, input logic [5:0] a, input logic [23:0] d);
		seed = xs(seed);
		host.xfer({wr, a, d, 1'b0}, 4 + int'(seed[1:0]), rd);
	endtask : access

	task automatic conclude;
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		i_resetn = 1'b0;
		repeat (10) @(posedge i_clk);
		#1 i_resetn = 1'b1;
		repeat (4) @(posedge i_clk);
		check("poll_period_reset", 32'(poll_period_ms), 32'd2);
		check("miso_oe_idle", 32'(miso_oe_n), 32'h1);
		access(1'b0, sicr_pkg::ADDR_INPUT_EN, 24'h0);
		check("input_enable_reset", 32'(rd), 32'h0);
		check("miso_oe_driven", 32'(oe_low), 32'h1);
		check("miso_oe_released", 32'(miso_oe_n), 32'h1);
		access(1'b0, sicr_pkg::ADDR_DIR_SELECT, 24'h0);
		check("direction_reset", 32'(rd), 32'h0);
		for (int c = 0; c < 16; c++)
		begin
			access(1'b1, sicr_pkg::ADDR_CONFIG, 24'(c << 1));
			access(1'b0, sicr_pkg::ADDR_CONFIG, 24'h0);
			check("config_read", 32'(rd), 32'(c << 1));
			check("poll_period", 32'(poll_period_ms), 32'(exp_ms(4'(c))));
		end
		access(1'b1, sicr_pkg::ADDR_CONFIG, 24'h0);
		for (int k = 0; k < 6; k++)
		begin
			seed = xs(seed);
			en = (k == 0) ? 24'hffffff : (k == 1) ? 24'h800001 : seed[23:0];
			access(1'b1, sicr_pkg::ADDR_INPUT_EN, en);
			access(1'b0, sicr_pkg::ADDR_INPUT_EN, 24'h0);
			check("input_enable_read", 32'(rd), 32'(en));
			check("input_enable_port", 32'(input_enable), 32'(en));
			seen = '0;
			// Three 2 ms periods hold at least two whole scans
			repeat (6 * CPM) @(posedge i_clk);
			check("polled_channels", 32'(seen), 32'(en));
		end
		for (int k = 0; k < 4; k++)
		begin
			seed = xs(seed);
			val = (k == 0) ? 24'hffffff : seed[23:0];
			access(1'b1, sicr_pkg::ADDR_DIR_SELECT, val);
			access(1'b0, sicr_pkg::ADDR_DIR_SELECT, 24'h0);
			check("direction_read", 32'(rd), 32'(val & 24'h0003ff));
			check("direction_port", 32'(direction_select), 32'(val[9:0]));
		end
		access(1'b1, 6'h3f, 24'h123456);
		access(1'b0, 6'h3f, 24'h0);
		check("unmapped_read", 32'(rd), 32'h0);
		check("direction_kept", 32'(direction_select), 32'(val[9:0]));
		access(1'b1, sicr_pkg::ADDR_CONFIG, 24'h000014);
		access(1'b0, sicr_pkg::ADDR_CONFIG, 24'h0);
		check("config_no_reset", 32'(rd), 32'h14);
		check("reset_count", 32'(resets), 32'd0);
		check("enable_kept", 32'(input_enable), 32'(en));
		access(1'b1, sicr_pkg::ADDR_CONFIG, 24'h000015);
		check("reset_count", 32'(resets), 32'd1);
		check("enable_cleared", 32'(input_enable), 32'h0);
		check("direction_cleared", 32'(direction_select), 32'h0);
		access(1'b0, sicr_pkg::ADDR_CONFIG, 24'h0);
		check("config_after_reset", 32'(rd), 32'h0);
		check("poll_after_reset", 32'(poll_period_ms), 32'd2);
		conclude();
	end

	// Hang guard
	initial
	begin
		repeat (60000) @(posedge i_clk);
		mismatches++;
		conclude();
	end
endmodule : tb_switch_input_config_regs
